// [hw/dtc_timer.v]
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ns
`include "dtc_map.vh"
module dtc_timer (
  input wire clk, // System clock, 20 MHz
  input wire rst, // Synchronous reset, active high
  input wire [5:0] avs_address, // Byte address
  input wire avs_read, // Read request
  input wire avs_write, // Write request
  input wire [31:0] avs_writedata, // Write data
  input wire [3:0] avs_byteenable, // Byte enables
  output reg [31:0] avs_readdata, // Read data
  output reg avs_waitrequest, // Stall until answer
  input wire count_pin_a, // External count pin, timer a
  input wire count_pin_b, // External count pin, timer b
  input wire gate_input_a, // Gate input, timer a
  input wire gate_input_b, // Gate input, timer b
  input wire external_clock_source, // External clock for prescaler
  input wire irq_vector_a, // Pulse: processor vectors to timer a
  input wire irq_vector_b, // Pulse: processor vectors to timer b
  output reg irq_a, // Interrupt request, timer a
  output reg irq_b // Interrupt request, timer b
);
  // Software-visible configuration
  reg timer_a_run_bit_q;
  reg timer_b_run_bit_q;
  reg timer_a_overflow_flag_q;
  reg timer_b_overflow_flag_q;
  reg [7:0] timer_mode_config_q;
  reg [7:0] clock_select_config_q;
  reg gate_a_polarity_q;
  reg gate_b_polarity_q;
  reg timer_a_irq_enable_q;
  reg timer_b_irq_enable_q;

  // Count pin samples for edge detection, gate pin samples for level checks
  reg pin_a_q;
  reg pin_a_prev_q;
  reg pin_b_q;
  reg pin_b_prev_q;
  reg gate_a_q;
  reg gate_b_q;

  // Bus decode
  wire [3:0] word_idx;
  wire acc;
  wire wr_acc;
  wire wr_b0;
  wire [7:0] wbyte;
  reg [7:0] rd_d;

  // Timer data paths
  wire [1:0] prescale_field;
  wire presc_tick;
  wire [3:0] cfg_a;
  wire [3:0] cfg_b;
  wire fall_a;
  wire fall_b;
  wire gate_ok_a;
  wire gate_ok_b;
  wire src_a;
  wire src_b;
  wire inc_a;
  wire inc_b;
  wire [7:0] a_lo;
  wire [7:0] a_hi;
  wire [7:0] b_lo;
  wire [7:0] b_hi;
  wire ovf_a;
  wire ovf_b;
  wire wr_ctrl;

  assign word_idx = avs_address[5:2];
  assign acc = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr_acc = avs_write & ~avs_waitrequest;
  assign wr_b0 = wr_acc & avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];
  assign wr_ctrl = wr_b0 && (word_idx == `DTC_OFS_CTRL);

  assign prescale_field = clock_select_config_q[1:0];
  assign cfg_a = timer_mode_config_q[3:0];
  assign cfg_b = timer_mode_config_q[`DTC_MODE_B_BASE + 3:`DTC_MODE_B_BASE];

  // Sample pins once per system clock
  always @(posedge clk) begin
    if (rst) begin
      pin_a_q <= 1'b1;
      pin_a_prev_q <= 1'b1;
      pin_b_q <= 1'b1;
      pin_b_prev_q <= 1'b1;
      gate_a_q <= 1'b0;
      gate_b_q <= 1'b0;
    end else begin
      pin_a_q <= count_pin_a;
      pin_a_prev_q <= pin_a_q;
      pin_b_q <= count_pin_b;
      pin_b_prev_q <= pin_b_q;
      gate_a_q <= gate_input_a;
      gate_b_q <= gate_input_b;
    end
  end

  // High-to-low transition seen between two samples
  assign fall_a = pin_a_prev_q & ~pin_a_q;
  assign fall_b = pin_b_prev_q & ~pin_b_q;

  // Gate input active at its programmed polarity
  assign gate_ok_a = ~cfg_a[`DTC_MODE_GATE] |
    (gate_a_q == gate_a_polarity_q);
  assign gate_ok_b = ~cfg_b[`DTC_MODE_GATE] |
    (gate_b_q == gate_b_polarity_q);

  // Timebase choice: pin edge, system clock, or prescaled tick
  assign src_a = cfg_a[`DTC_MODE_CT] ? fall_a :
    (clock_select_config_q[`DTC_CLK_SYS_A] ? 1'b1 : presc_tick);
  assign src_b = cfg_b[`DTC_MODE_CT] ? fall_b :
    (clock_select_config_q[`DTC_CLK_SYS_B] ? 1'b1 : presc_tick);

  // Run alone never clears the count; it only enables stepping
  assign inc_a = timer_a_run_bit_q & gate_ok_a & src_a;
  assign inc_b = timer_b_run_bit_q & gate_ok_b & src_b;

  // Shared prescaler feeding both timers
  dtc_prescale u_presc (
    .clk(clk),
    .rst(rst),
    .sel(prescale_field),
    .ext_clk(external_clock_source),
    .tick_q(presc_tick)
  );

  // Timer a count
  dtc_counter u_cnt_a (
    .clk(clk),
    .rst(rst),
    .inc(inc_a),
    .mode(cfg_a[1:0]),
    .wr_lo(wr_b0 && (word_idx == `DTC_OFS_A_LO)),
    .wr_hi(wr_b0 && (word_idx == `DTC_OFS_A_HI)),
    .wdata(wbyte),
    .lo_q(a_lo),
    .hi_q(a_hi),
    .ovf_q(ovf_a)
  );

  // Timer b count
  dtc_counter u_cnt_b (
    .clk(clk),
    .rst(rst),
    .inc(inc_b),
    .mode(cfg_b[1:0]),
    .wr_lo(wr_b0 && (word_idx == `DTC_OFS_B_LO)),
    .wr_hi(wr_b0 && (word_idx == `DTC_OFS_B_HI)),
    .wdata(wbyte),
    .lo_q(b_lo),
    .hi_q(b_hi),
    .ovf_q(ovf_b)
  );

  // Configuration registers written by software
  always @(posedge clk) begin
    if (rst) begin
      timer_a_run_bit_q <= 1'b0;
      timer_b_run_bit_q <= 1'b0;
      timer_mode_config_q <= `DTC_RST_BYTE;
      clock_select_config_q <= `DTC_RST_BYTE;
      gate_a_polarity_q <= 1'b0;
      gate_b_polarity_q <= 1'b0;
      timer_a_irq_enable_q <= 1'b0;
      timer_b_irq_enable_q <= 1'b0;
    end else if (wr_b0) begin
      case (word_idx)
        `DTC_OFS_CTRL: begin
          timer_a_run_bit_q <= wbyte[`DTC_CTRL_RUN_A];
          timer_b_run_bit_q <= wbyte[`DTC_CTRL_RUN_B];
        end
        `DTC_OFS_MODE: begin
          timer_mode_config_q <= wbyte;
        end
        `DTC_OFS_CLKSEL: begin
          clock_select_config_q <= {3'h0, wbyte[4:3], 1'b0, wbyte[1:0]};
        end
        `DTC_OFS_EXTCFG: begin
          gate_a_polarity_q <= wbyte[`DTC_POL_A];
          gate_b_polarity_q <= wbyte[`DTC_POL_B];
        end
        `DTC_OFS_IRQEN: begin
          timer_a_irq_enable_q <= wbyte[`DTC_IE_A];
          timer_b_irq_enable_q <= wbyte[`DTC_IE_B];
        end
        default: begin
          timer_a_run_bit_q <= timer_a_run_bit_q;
        end
      endcase
    end
  end

  // Overflow flags: set beats software clear and vector clear
  always @(posedge clk) begin
    if (rst) begin
      timer_a_overflow_flag_q <= 1'b0;
      timer_b_overflow_flag_q <= 1'b0;
    end else begin
      if (ovf_a) begin
        timer_a_overflow_flag_q <= 1'b1;
      end else if (irq_vector_a) begin
        timer_a_overflow_flag_q <= 1'b0;
      end else if (wr_ctrl) begin
        timer_a_overflow_flag_q <= wbyte[`DTC_CTRL_FLAG_A];
      end
      if (ovf_b) begin
        timer_b_overflow_flag_q <= 1'b1;
      end else if (irq_vector_b) begin
        timer_b_overflow_flag_q <= 1'b0;
      end else if (wr_ctrl) begin
        timer_b_overflow_flag_q <= wbyte[`DTC_CTRL_FLAG_B];
      end
    end
  end

  // Interrupt requests follow flag and enable
  always @(posedge clk) begin
    if (rst) begin
      irq_a <= 1'b0;
      irq_b <= 1'b0;
    end else begin
      irq_a <= timer_a_overflow_flag_q & timer_a_irq_enable_q;
      irq_b <= timer_b_overflow_flag_q & timer_b_irq_enable_q;
    end
  end

  // Read mux; unmapped words read as zero
  always @* begin
    case (word_idx)
      `DTC_OFS_CTRL: rd_d = {timer_b_overflow_flag_q, timer_b_run_bit_q,
        timer_a_overflow_flag_q, timer_a_run_bit_q, 4'h0};
      `DTC_OFS_MODE: rd_d = timer_mode_config_q;
      `DTC_OFS_CLKSEL: rd_d = clock_select_config_q;
      `DTC_OFS_EXTCFG: rd_d = {gate_b_polarity_q, 3'h0, gate_a_polarity_q, 3'h0};
      `DTC_OFS_IRQEN: rd_d = {4'h0, timer_b_irq_enable_q, 1'b0,
        timer_a_irq_enable_q, 1'b0};
      `DTC_OFS_A_LO: rd_d = a_lo;
      `DTC_OFS_A_HI: rd_d = a_hi;
      `DTC_OFS_B_LO: rd_d = b_lo;
      `DTC_OFS_B_HI: rd_d = b_hi;
      default: rd_d = 8'h00;
    endcase
  end

  // One wait state: drop waitrequest with data, then complete
  always @(posedge clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else if (acc) begin
      avs_waitrequest <= 1'b1;
    end else if (avs_read | avs_write) begin
      avs_waitrequest <= 1'b0;
      // Read data hold until the next read answer, writes leave them alone
      if (avs_read) begin
        avs_readdata <= {24'h000000, rd_d};
      end
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end
endmodule // dtc_timer

// [hw/dtc_map.vh]
`ifndef DTC_MAP_VH
`define DTC_MAP_VH
// Register word offsets on the Avalon-MM slave, compared with byte address bits [5:2]
`define DTC_OFS_CTRL 4'h0
`define DTC_OFS_MODE 4'h1
`define DTC_OFS_CLKSEL 4'h2
`define DTC_OFS_EXTCFG 4'h3
`define DTC_OFS_IRQEN 4'h4
`define DTC_OFS_A_LO 4'h5
`define DTC_OFS_A_HI 4'h6
`define DTC_OFS_B_LO 4'h7
`define DTC_OFS_B_HI 4'h8
// Control register fields
`define DTC_CTRL_RUN_A 4
`define DTC_CTRL_FLAG_A 5
`define DTC_CTRL_RUN_B 6
`define DTC_CTRL_FLAG_B 7
// Mode register fields (timer a in [3:0], timer b in [7:4])
`define DTC_MODE_B_BASE 4
`define DTC_MODE_CT 2
`define DTC_MODE_GATE 3
// Clock select fields
`define DTC_CLK_SYS_A 3
`define DTC_CLK_SYS_B 4
// Gate polarity and interrupt enable fields
`define DTC_POL_A 3
`define DTC_POL_B 7
`define DTC_IE_A 1
`define DTC_IE_B 3
// Mode codes
`define DTC_MODE_13 2'h0
`define DTC_MODE_16 2'h1
`define DTC_MODE_RELOAD 2'h2
`define DTC_MODE_OFF 2'h3
// Reset values
`define DTC_RST_BYTE 8'h00
// Prescale divisors
`define DTC_DIV_12 6'h0c
`define DTC_DIV_4 6'h04
`define DTC_DIV_48 6'h30
`define DTC_DIV_EXT 6'h08
`endif

// [hw/dtc_prescale.v]
`timescale 1ns/1ns
`include "dtc_map.vh"
module dtc_prescale (
  input wire clk, // System clock
  input wire rst, // Synchronous reset, active high
  input wire [1:0] sel, // Prescale field
  input wire ext_clk, // External clock source, synchronous samples
  output reg tick_q // One-cycle prescaled tick
);
  reg [5:0] div_q;
  reg ext_q;
  reg ext_prev_q;
  wire ext_rise;
  reg [5:0] limit;
  wire step;

  // Divisor for each prescale code
  always @* begin
    case (sel)
      2'h0: limit = `DTC_DIV_12;
      2'h1: limit = `DTC_DIV_4;
      2'h2: limit = `DTC_DIV_48;
      default: limit = `DTC_DIV_EXT;
    endcase
  end

  assign ext_rise = ext_q & ~ext_prev_q;
  assign step = (sel == 2'h3) ? ext_rise : 1'b1;

  // Divider counts system cycles or external rising edges
  always @(posedge clk) begin
    if (rst) begin
      div_q <= 6'h00;
      ext_q <= 1'b0;
      ext_prev_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      ext_q <= ext_clk;
      ext_prev_q <= ext_q;
      tick_q <= 1'b0;
      if (step) begin
        if (div_q >= limit - 6'h01) begin
          div_q <= 6'h00;
          tick_q <= 1'b1;
        end else begin
          div_q <= div_q + 6'h01;
        end
      end
    end
  end
endmodule // dtc_prescale

// [hw/dtc_counter.v]
`timescale 1ns/1ns
`include "dtc_map.vh"
module dtc_counter (
  input wire clk, // System clock
  input wire rst, // Synchronous reset, active high
  input wire inc, // Count one step this cycle
  input wire [1:0] mode, // Mode field
  input wire wr_lo, // Software write of low byte
  input wire wr_hi, // Software write of high byte
  input wire [7:0] wdata, // Write data
  output reg [7:0] lo_q, // Low count byte
  output reg [7:0] hi_q, // High count byte
  output reg ovf_q // One-cycle overflow pulse
);
  wire [12:0] c13;
  wire [15:0] c16;
  assign c13 = {hi_q, lo_q[4:0]};
  assign c16 = {hi_q, lo_q};

  // Count update; a write wins over an increment in the same cycle
  always @(posedge clk) begin
    if (rst) begin
      lo_q <= `DTC_RST_BYTE;
      hi_q <= `DTC_RST_BYTE;
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= 1'b0;
      if (wr_lo || wr_hi) begin
        if (wr_lo) lo_q <= wdata;
        if (wr_hi) hi_q <= wdata;
      end else if (inc) begin
        case (mode)
          `DTC_MODE_13: begin
            // Upper three low-byte bits are left untouched
            {hi_q, lo_q[4:0]} <= c13 + 13'h0001;
            ovf_q <= &c13;
          end
          `DTC_MODE_16: begin
            {hi_q, lo_q} <= c16 + 16'h0001;
            ovf_q <= &c16;
          end
          `DTC_MODE_RELOAD: begin
            lo_q <= (&lo_q) ? hi_q : lo_q + 8'h01;
            ovf_q <= &lo_q;
          end
          default: begin
            ovf_q <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule // dtc_counter

// [dv/dtc_timer_sva.sv]
`timescale 1ns/1ns
module dtc_timer_sva (
  input wire clk, // System clock
  input wire rst, // Synchronous reset
  input wire avs_read, // Read request
  input wire avs_write, // Write request
  input wire [31:0] avs_readdata, // Read data
  input wire avs_waitrequest, // Stall
  input wire irq_vector_a, // Vector pulse a
  input wire irq_vector_b, // Vector pulse b
  input wire irq_a, // Interrupt a
  input wire irq_b // Interrupt b
);
  // Bus handshake and interrupt relations
  AST_RST_QUIET: assert property (@(posedge clk)
    rst |=> avs_waitrequest && !irq_a && !irq_b) else $error("outputs not quiet in reset");
  AST_ANSWER: assert property (@(posedge clk) disable iff (rst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
  AST_ONE_CYCLE: assert property (@(posedge clk) disable iff (rst)
    !avs_waitrequest |=> avs_waitrequest) else $error("answer too long");
  AST_IDLE_HIGH: assert property (@(posedge clk) disable iff (rst)
    !avs_read && !avs_write |=> avs_waitrequest) else $error("answer without request");
  AST_NO_SPURIOUS: assert property (@(posedge clk) disable iff (rst)
    $fell(avs_waitrequest) |-> $past(avs_read || avs_write)) else $error("spurious answer");
  AST_UPPER_ZERO: assert property (@(posedge clk) disable iff (rst)
    avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0) else $error("upper bits set");
  AST_RD_HOLD: assert property (@(posedge clk) disable iff (rst)
    !(avs_read && !avs_waitrequest) |-> $stable(avs_readdata)) else $error("read data moved");
  AST_VEC_A: assert property (@(posedge clk) disable iff (rst)
    irq_vector_a |-> ##3 !irq_a) else $error("vector a kept irq");
  AST_VEC_B: assert property (@(posedge clk) disable iff (rst)
    irq_vector_b |-> ##3 !irq_b) else $error("vector b kept irq");
endmodule // dtc_timer_sva
bind dtc_timer dtc_timer_sva u_dtc_timer_sva (.clk(clk), .rst(rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .irq_vector_a(irq_vector_a), .irq_vector_b(irq_vector_b), .irq_a(irq_a), .irq_b(irq_b));

// [dv/dtc_pins_model.sv]
`timescale 1ns/1ns
module dtc_pins_model (
  input wire clk, // System clock
  output reg count_pin_a, // Count pin a, idles high
  output reg count_pin_b, // Count pin b, idles high
  output reg gate_input_a, // Gate a
  output reg gate_input_b, // Gate b
  output reg external_clock_source // Free running oscillator
);
  reg [2:0] div_q = 3'h0;
  initial begin
    count_pin_a = 1'b1;
    count_pin_b = 1'b1;
    gate_input_a = 1'b0;
    gate_input_b = 1'b0;
    external_clock_source = 1'b0;
  end
  // Oscillator toggles every five system clocks
  always @(posedge clk) begin
    div_q <= (div_q == 3'h4) ? 3'h0 : div_q + 3'h1;
    if (div_q == 3'h4) external_clock_source <= !external_clock_source;
  end
  // Falling edges on chosen pins at a quarter of the system rate
  task pulse(input sa, input sb, input integer n);
    integer k;
    for (k = 0; k < n; k = k + 1) begin
      count_pin_a <= !sa;
      count_pin_b <= !sb;
      repeat (2) @(posedge clk);
      count_pin_a <= 1'b1;
      count_pin_b <= 1'b1;
      repeat (2) @(posedge clk);
    end
  endtask
  // Gate levels, given time to settle
  task gate(input a, input b);
    gate_input_a <= a;
    gate_input_b <= b;
    repeat (3) @(posedge clk);
  endtask
endmodule // dtc_pins_model

// [dv/dtc_timer_tb_top.sv]
`timescale 1ns/1ns
module dtc_timer_tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [5:0] avs_address = 6'h00;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  reg [3:0] avs_byteenable = 4'hf;
  reg irq_vector_a = 1'b0;
  reg irq_vector_b = 1'b0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, irq_a, irq_b, pa, pb, ga, gb, xc;
  integer bad_count = 0;
  integer cmp_count = 0;
  integer i;
  reg [7:0] lfsr_q = 8'h58;
  reg [7:0] v, lo, hi, m;
  reg [31:0] d;
  reg [7:0] q_lo[$], q_hi[$], q_m[$];
  always #25 clk = !clk;
  dtc_timer u_dtc_timer (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .count_pin_a(pa), .count_pin_b(pb),
    .gate_input_a(ga), .gate_input_b(gb), .external_clock_source(xc),
    .irq_vector_a(irq_vector_a), .irq_vector_b(irq_vector_b), .irq_a(irq_a), .irq_b(irq_b));
  dtc_pins_model u_dtc_pins_model (.clk(clk), .count_pin_a(pa), .count_pin_b(pb),
    .gate_input_a(ga), .gate_input_b(gb), .external_clock_source(xc));
  function [7:0] nxt(input [7:0] x);
    nxt = {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  task stop_test;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // One bus access, held until waitrequest is sampled low
  task bus(input r, input [5:0] a, input [7:0] wd);
    integer n;
    begin
      n = 0;
      @(posedge clk);
      avs_read <= r;
      avs_write <= !r;
      avs_address <= a;
      avs_writedata <= {24'h0, wd};
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && n < 20) begin
        @(posedge clk);
        n = n + 1;
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 20) begin
        bad_count = bad_count + 1;
        stop_test;
      end
    end
  endtask
  task wr(input [5:0] a, input [7:0] wd);
    bus(1'b0, a, wd);
  endtask
  // Note the accepted range under a mask, then read
  task rd(input [5:0] a, input [7:0] l, input [7:0] h, input [7:0] mk);
    begin
      q_lo.push_back(l);
      q_hi.push_back(h);
      q_m.push_back(mk);
      bus(1'b1, a, 8'h00);
    end
  endtask
  task cmp_bit(input b, input e);
    begin
      cmp_count = cmp_count + 1;
      if (b !== e) begin
        bad_count = bad_count + 1;
        $display("wrong value at %0t: irq %b", $time, b);
      end
    end
  endtask
  // Read answers are compared with the oldest note
  always @(posedge clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      lo = q_lo.pop_front();
      hi = q_hi.pop_front();
      m = q_m.pop_front();
      d = avs_readdata & {24'hffffff, m};
      cmp_count = cmp_count + 1;
      if ((d >= {24'h0, lo} && d <= {24'h0, hi}) !== 1'b1) begin
        bad_count = bad_count + 1;
        $display("wrong value at %0t: read %h want %h to %h", $time, avs_readdata, lo, hi);
      end
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // A write with byte lane zero disabled is answered but ignored
    avs_byteenable <= 4'he;
    wr(6'h14, 8'ha5);
    avs_byteenable <= 4'hf;
    for (i = 0; i < 10; i = i + 1) rd({i[3:0], 2'b00}, 8'h00, 8'h00, 8'hff);
    for (i = 5; i < 9; i = i + 1) begin
      lfsr_q = nxt(lfsr_q);
      v = i[0] ? 8'h1f : 8'hff;
      wr({i[3:0], 2'b00}, lfsr_q);
      rd({i[3:0], 2'b00}, lfsr_q & v, lfsr_q & v, v);
    end
    // Timer a 16-bit counting, timer b 13-bit gated, irq a only
    wr(6'h04, 8'hc5);
    wr(6'h0c, 8'h80);
    wr(6'h10, 8'h02);
    wr(6'h14, 8'hfe);
    wr(6'h18, 8'hff);
    wr(6'h1c, 8'h1f);
    wr(6'h20, 8'hff);
    wr(6'h00, 8'h50);
    rd(6'h14, 8'hfe, 8'hfe, 8'hff);
    u_dtc_pins_model.pulse(1'b1, 1'b1, 3);
    rd(6'h14, 8'h01, 8'h01, 8'hff);
    rd(6'h18, 8'h00, 8'h00, 8'hff);
    rd(6'h1c, 8'h1f, 8'h1f, 8'h1f);
    rd(6'h00, 8'h70, 8'h70, 8'hf0);
    cmp_bit(irq_a, 1'b1);
    u_dtc_pins_model.gate(1'b0, 1'b1);
    u_dtc_pins_model.pulse(1'b0, 1'b1, 1);
    rd(6'h20, 8'h00, 8'h00, 8'hff);
    rd(6'h00, 8'hf0, 8'hf0, 8'hf0);
    cmp_bit(irq_b, 1'b0);
    @(posedge clk);
    irq_vector_a <= 1'b1;
    @(posedge clk);
    irq_vector_a <= 1'b0;
    repeat (3) @(posedge clk);
    cmp_bit(irq_a, 1'b0);
    rd(6'h00, 8'hd0, 8'hd0, 8'hf0);
    // Enable timer b interrupt on its pending flag, then vector it away
    wr(6'h10, 8'h0a);
    repeat (2) @(posedge clk);
    cmp_bit(irq_b, 1'b1);
    @(posedge clk);
    irq_vector_b <= 1'b1;
    @(posedge clk);
    irq_vector_b <= 1'b0;
    repeat (3) @(posedge clk);
    cmp_bit(irq_b, 1'b0);
    rd(6'h00, 8'h50, 8'h50, 8'hf0);
    // Each prescaler setting and the system clock timebase over a fixed run window
    wr(6'h04, 8'h01);
    for (i = 0; i < 5; i = i + 1) begin
      wr(6'h00, 8'h00);
      wr(6'h14, 8'h00);
      wr(6'h18, 8'h00);
      wr(6'h08, (i == 4) ? 8'h08 : i[7:0]);
      wr(6'h00, 8'h10);
      repeat (240) @(posedge clk);
      wr(6'h00, 8'h00);
      v = (i == 0) ? 8'h14 : (i == 1) ? 8'h3c : (i == 2) ? 8'h05 : (i == 3) ? 8'h03 : 8'hf3;
      rd(6'h14, v - 8'h01, v + 8'h02, 8'hff);
    end
    // Byte write during system clock counting suppresses that step
    wr(6'h14, 8'h10);
    wr(6'h00, 8'h10);
    wr(6'h18, 8'h5a);
    wr(6'h00, 8'h00);
    rd(6'h14, 8'h15, 8'h15, 8'hff);
    rd(6'h18, 8'h5a, 8'h5a, 8'hff);
    // Mode three holds the count while running
    wr(6'h04, 8'h03);
    wr(6'h00, 8'h10);
    wr(6'h00, 8'h00);
    rd(6'h14, 8'h15, 8'h15, 8'hff);
    // Mode two reloads the low byte from the high byte on wrap
    wr(6'h04, 8'h02);
    wr(6'h14, 8'hfe);
    wr(6'h00, 8'h10);
    wr(6'h00, 8'h00);
    rd(6'h14, 8'h5b, 8'h5b, 8'hff);
    rd(6'h00, 8'h20, 8'h20, 8'hf0);
    stop_test;
  end
endmodule // dtc_timer_tb_top
